//--- bench/rsf_status_asserts.sv
// concurrent checks on the radio status flag block
`timescale 1ns/1ns
module rsf_status_asserts #(
	parameter int unsigned GROUP_PULSE_CYCLES = rsf_pkg::GROUP_PULSE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic irq,
	input wire logic group_int_n,
	input wire logic [7:0] scan_channel,
	input wire logic scan_active,
	input wire logic channel_valid,
	input wire logic audio_serial_overflow,
	input wire logic audio_serial_underflow,
	input wire logic input_saturated,
	input wire logic gain_settled,
	input wire logic gain_error,
	input wire logic mono_indicator,
	input wire logic group_received,
	input wire logic group_fetched,
	input wire logic extra_block_detect,
	input wire logic third_block_type,
	input wire logic block_sync,
	input wire logic byte0_error_flag,
	input wire logic byte1_error_flag,
	input wire logic byte2_error_flag,
	input wire logic byte3_error_flag
);
	// ************************************************************
	// shadow of control state, scan last and group toggle
	// ************************************************************
	logic tx_mode_q;
	logic int_en_q;
	logic toggle_q;
	logic [7:0] last_q;
	wire ctl_wr = reg_wr && (reg_addr == rsf_pkg::ADDR_CONTROL);
	wire group_ev = tx_mode_q ? group_fetched : group_received;
	wire ev_wr = reg_wr && (reg_addr == rsf_pkg::ADDR_EVENT_STATUS || reg_addr == rsf_pkg::ADDR_EVENT_MASK);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_mode_q <= 1'b0;
			int_en_q <= 1'b0;
			toggle_q <= 1'b0;
			last_q <= 8'hFF;
		end else begin
			if (ctl_wr) begin
				tx_mode_q <= reg_wdata[rsf_pkg::CTRL_TX_MODE];
				int_en_q <= reg_wdata[rsf_pkg::CTRL_GROUP_INT_EN];
			end
			if (reg_wr && reg_addr == rsf_pkg::ADDR_SCAN_LAST) begin
				last_q <= reg_wdata;
			end
			if (group_ev) begin
				toggle_q <= !toggle_q;
			end
		end
	end
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_pulse_trig;
		group_fetched && tx_mode_q && int_en_q;
	endsequence
	sequence s_scan_req;
		ctl_wr && reg_wdata[rsf_pkg::CTRL_SCAN_START] && !scan_active;
	endsequence
	rx_image_a: assert property (reg_rd && reg_addr == rsf_pkg::ADDR_RECEIVE_STATUS |=>
		!reg_rdata[7] && reg_rdata[5:0] ==
		$past({audio_serial_overflow, audio_serial_underflow, input_saturated, gain_settled, gain_error, mono_indicator}))
		else $error("receive status image wrong");
	ds_image_a: assert property (reg_rd && reg_addr == rsf_pkg::ADDR_DATA_SERVICE_STATUS |=>
		reg_rdata == {$past(toggle_q),
		$past({extra_block_detect, third_block_type, block_sync, byte0_error_flag, byte1_error_flag, byte2_error_flag,
		byte3_error_flag})}) else $error("data service status image wrong");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read");
	pulse_start_a: assert property (s_pulse_trig |=> !group_int_n [*8])
		else $error("group pulse missing");
	pulse_cause_a: assert property ($fell(group_int_n) |-> $past(group_fetched && tx_mode_q && int_en_q))
		else $error("group pulse without fetch");
	scan_start_a: assert property (s_scan_req |=> scan_active)
		else $error("scan did not start");
	scan_hold_a: assert property (!$past(scan_active) |-> $stable(scan_channel))
		else $error("channel moved while idle");
	scan_stop_a: assert property ($fell(scan_active) |->
		$past(channel_valid) || scan_channel == last_q)
		else $error("scan stopped on wrong channel");
	irq_fall_a: assert property ($fell(irq) |-> $past(ev_wr) || $past(ev_wr, 2))
		else $error("interrupt dropped without write");
endmodule // rsf_status_asserts

bind rsf_status rsf_status_asserts #(.GROUP_PULSE_CYCLES(GROUP_PULSE_CYCLES)) rsf_status_asserts_inst (.sys_clk, .rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .group_int_n, .scan_channel, .scan_active, .channel_valid,
	.audio_serial_overflow, .audio_serial_underflow, .input_saturated, .gain_settled, .gain_error, .mono_indicator,
	.group_received, .group_fetched, .extra_block_detect, .third_block_type, .block_sync, .byte0_error_flag,
	.byte1_error_flag, .byte2_error_flag, .byte3_error_flag);

//--- bench/rsf_status_tb.sv
// self-checking bench for the radio status flag block
`timescale 1ns/1ns
module rsf_status_tb;
	// ************************************************************
	// signals and design
	// ************************************************************
	localparam int unsigned PULSE = 20;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic irq;
	logic group_int_n;
	logic [7:0] scan_channel;
	logic scan_active;
	logic channel_valid;
	logic audio_serial_overflow, audio_serial_underflow, input_saturated, gain_settled, gain_error, mono_indicator;
	logic extra_block_detect, third_block_type, block_sync;
	logic byte0_error_flag, byte1_error_flag, byte2_error_flag, byte3_error_flag;
	logic group_received = 1'b0;
	logic group_fetched = 1'b0;
	logic [5:0] rx_f = 6'h00;
	logic [6:0] ds_f = 7'h00;
	logic [7:0] valid_ch = 8'hFF;
	int n_fail = 0;
	int n_checks = 0;
	int cycles = 0;
	int n;
	assign {audio_serial_overflow, audio_serial_underflow, input_saturated, gain_settled, gain_error,
		mono_indicator} = rx_f;
	assign {extra_block_detect, third_block_type, block_sync, byte0_error_flag, byte1_error_flag, byte2_error_flag,
		byte3_error_flag} = ds_f;
	assign channel_valid = (scan_channel == valid_ch);
	always #25 sys_clk = ~sys_clk;
	rsf_status #(.GROUP_PULSE_CYCLES(PULSE)) rsf_status_inst (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .irq, .group_int_n, .scan_channel, .scan_active, .channel_valid, .audio_serial_overflow,
		.audio_serial_underflow, .input_saturated, .gain_settled, .gain_error, .mono_indicator, .group_received,
		.group_fetched, .extra_block_detect, .third_block_type, .block_sync, .byte0_error_flag, .byte1_error_flag,
		.byte2_error_flag, .byte3_error_flag);
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic give_verdict();
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), exp, reg_rdata);
	endtask
	task automatic pulse_grp(input logic fetch);
		@(posedge sys_clk);
		group_fetched <= fetch;
		group_received <= !fetch;
		@(posedge sys_clk);
		group_fetched <= 1'b0;
		group_received <= 1'b0;
		#1;
	endtask
	task automatic scan(input logic [7:0] vch);
		valid_ch = vch;
		wr(8'h20, 8'h01);
		n = 0;
		while (scan_active === 1'b1 && n < 1000) begin
			tick(1);
			n++;
		end
		chk("scan busy", 8'h00, {7'h00, scan_active});
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 3000) begin
			n_fail++;
			give_verdict();
		end
	end
	// ************************************************************
	// sequence of tests
	// ************************************************************
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h1A, 8'h00);
		rd(8'h1B, 8'h00);
		rd(8'h22, 8'hFF);
		rd(8'h25, 8'h00);
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			rx_f <= 6'h01 << i;
			rd(8'h1A, {2'b00, 6'h01 << i});
			wr(8'h1A, 8'h00);
			rd(8'h1A, {2'b00, 6'h01 << i});
		end
		for (int i = 0; i < 7; i++) begin
			@(posedge sys_clk);
			ds_f <= 7'h01 << i;
			rd(8'h1B, {1'b0, 7'h01 << i});
			wr(8'h1B, 8'hFF);
			rd(8'h1B, {1'b0, 7'h01 << i});
		end
		@(posedge sys_clk);
		rx_f <= 6'h00;
		ds_f <= 7'h00;
		rd(8'h7F, 8'h00);
		rd(8'h24, 8'hBC);
		chk("irq", 8'h00, {7'h00, irq});
		wr(8'h25, 8'h04);
		tick(2);
		chk("irq", 8'h01, {7'h00, irq});
		wr(8'h24, 8'hFF);
		tick(2);
		chk("irq", 8'h00, {7'h00, irq});
		wr(8'h21, 8'h05);
		wr(8'h22, 8'h07);
		wr(8'h25, 8'h02);
		scan(8'hFF);
		chk("channel", 8'h07, scan_channel);
		rd(8'h1A, 8'h40);
		rd(8'h24, 8'h03);
		chk("irq", 8'h01, {7'h00, irq});
		wr(8'h24, 8'hFF);
		scan(8'h06);
		chk("channel", 8'h06, scan_channel);
		rd(8'h1A, 8'h00);
		rd(8'h24, 8'h01);
		chk("irq", 8'h00, {7'h00, irq});
		wr(8'h24, 8'hFF);
		pulse_grp(1'b0);
		rd(8'h1B, 8'h80);
		pulse_grp(1'b1);
		rd(8'h1B, 8'h80);
		chk("int pin", 8'h01, {7'h00, group_int_n});
		wr(8'h20, 8'h06);
		pulse_grp(1'b1);
		chk("int pin", 8'h00, {7'h00, group_int_n});
		n = 0;
		while (group_int_n === 1'b0 && n < 100) begin
			tick(1);
			n++;
		end
		chk("pulse length", 8'(PULSE), 8'(n));
		rd(8'h1B, 8'h00);
		pulse_grp(1'b0);
		rd(8'h1B, 8'h00);
		wr(8'h20, 8'h04);
		pulse_grp(1'b1);
		chk("int pin", 8'h01, {7'h00, group_int_n});
		rd(8'h1B, 8'h80);
		rd(8'h24, 8'h40);
		@(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h1B, 8'h00);
		rd(8'h20, 8'h00);
		rd(8'h24, 8'h00);
		give_verdict();
	end
endmodule // rsf_status_tb

//--- include/rsf_pkg.sv
// package of constants for the radio status flag block
package rsf_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned GROUP_PULSE_US = 4500;
	localparam int unsigned GROUP_PULSE_CYCLES = (GROUP_PULSE_US * (CLK_HZ / 1_000_000));
	localparam int unsigned SCAN_DWELL_NS = 1000;
	localparam int unsigned SCAN_DWELL_CYCLES = (SCAN_DWELL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PULSE_CNT_W = 17;
	localparam int DWELL_CNT_W = 8;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_RECEIVE_STATUS = 8'h1A;
	localparam logic [7:0] ADDR_DATA_SERVICE_STATUS = 8'h1B;
	localparam logic [7:0] ADDR_CONTROL = 8'h20;
	localparam logic [7:0] ADDR_SCAN_FIRST = 8'h21;
	localparam logic [7:0] ADDR_SCAN_LAST = 8'h22;
	localparam logic [7:0] ADDR_SCAN_CHANNEL = 8'h23;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h24;
	localparam logic [7:0] ADDR_EVENT_MASK = 8'h25;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_SCAN_START = 0;
	localparam int CTRL_GROUP_INT_EN = 1;
	localparam int CTRL_TX_MODE = 2;
	localparam int EV_SCAN_DONE = 0;
	localparam int EV_SCAN_FAIL = 1;
	localparam int EV_OVERFLOW = 2;
	localparam int EV_UNDERFLOW = 3;
	localparam int EV_SATURATION = 4;
	localparam int EV_GAIN_ERROR = 5;
	localparam int EV_GROUP_TOGGLE = 6;
	localparam int EV_SYNC_LOST = 7;
	localparam int EV_COUNT = 8;

	// ************************************************************
	// reset values and scan channel step
	// ************************************************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_SCAN_LAST = 8'hFF;
	localparam logic RST_BIT = 1'b0;
	localparam logic RST_PULSE_N = 1'b1;
	localparam logic [7:0] CHANNEL_STEP = 8'h01;

	// ************************************************************
	// scan sequencer states
	// ************************************************************
	typedef enum logic [1:0] {
		RSF_SCAN_IDLE = 2'b00,
		RSF_SCAN_LOAD = 2'b01,
		RSF_SCAN_RUN = 2'b10
	} rsf_scan_state_t;

endpackage

//--- rtl/rsf_status.sv
// radio status flag register bank with scan sequencer and interrupts
//
// Operation
// - Receive status at 1Ah, read-only: 0, scan fail, overflow, underflow, saturation, settled, gain error, mono.
// - A channel scan that finds a valid channel stops with the index on that channel and clears scan fail.
// - A channel scan that finds no valid channel stops with the index at the end of the range and sets scan fail.
// - Bit 5 of the receive status is 1 while the audio serial path overflows and 0 otherwise.
// - Bit 4 of the receive status is 1 while the audio serial path underflows and 0 otherwise.
// - Bit 3 of the receive status is 1 while the input saturates and 0 otherwise.
// - Bit 2 of the receive status is 1 once receive gain control has settled and 0 before.
// - Data service status at 1Bh, read-only: toggle, extra block, third block type, sync, byte 0 to 3 errors.
// - In receive mode the group toggle inverts on each complete new group received.
// - In transmit mode the toggle inverts when user bytes are fetched, with a 4.5 ms low pulse if enabled.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
module rsf_status #(
	parameter int unsigned GROUP_PULSE_CYCLES = rsf_pkg::GROUP_PULSE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq,
	output logic group_int_n,
	output logic [7:0] scan_channel,
	output logic scan_active,
	input wire logic channel_valid,
	input wire logic audio_serial_overflow,
	input wire logic audio_serial_underflow,
	input wire logic input_saturated,
	input wire logic gain_settled,
	input wire logic gain_error,
	input wire logic mono_indicator,
	input wire logic group_received,
	input wire logic group_fetched,
	input wire logic extra_block_detect,
	input wire logic third_block_type,
	input wire logic block_sync,
	input wire logic byte0_error_flag,
	input wire logic byte1_error_flag,
	input wire logic byte2_error_flag,
	input wire logic byte3_error_flag
);

	// ************************************************************
	// register decode
	// ************************************************************
	wire logic sel_receive_status = (reg_addr == rsf_pkg::ADDR_RECEIVE_STATUS);
	wire logic sel_data_status = (reg_addr == rsf_pkg::ADDR_DATA_SERVICE_STATUS);
	wire logic sel_control = (reg_addr == rsf_pkg::ADDR_CONTROL);
	wire logic sel_scan_first = (reg_addr == rsf_pkg::ADDR_SCAN_FIRST);
	wire logic sel_scan_last = (reg_addr == rsf_pkg::ADDR_SCAN_LAST);
	wire logic sel_scan_channel = (reg_addr == rsf_pkg::ADDR_SCAN_CHANNEL);
	wire logic sel_event_status = (reg_addr == rsf_pkg::ADDR_EVENT_STATUS);
	wire logic sel_event_mask = (reg_addr == rsf_pkg::ADDR_EVENT_MASK);

	wire logic wr_control = reg_wr && sel_control;
	wire logic wr_scan_first = reg_wr && sel_scan_first;
	wire logic wr_scan_last = reg_wr && sel_scan_last;
	wire logic wr_event_status = reg_wr && sel_event_status;
	wire logic wr_event_mask = reg_wr && sel_event_mask;

	// ************************************************************
	// software registers
	// ************************************************************
	logic group_int_en;
	logic tx_mode;
	logic [7:0] scan_first;
	logic [7:0] scan_last;
	logic [7:0] event_mask;
	logic scan_fail;
	logic group_toggle;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			group_int_en <= rsf_pkg::RST_BIT;
			tx_mode <= rsf_pkg::RST_BIT;
		end else if (wr_control) begin
			group_int_en <= reg_wdata[rsf_pkg::CTRL_GROUP_INT_EN];
			tx_mode <= reg_wdata[rsf_pkg::CTRL_TX_MODE];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scan_first <= rsf_pkg::RST_BYTE;
		end else if (wr_scan_first) begin
			scan_first <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scan_last <= rsf_pkg::RST_SCAN_LAST;
		end else if (wr_scan_last) begin
			scan_last <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			event_mask <= rsf_pkg::RST_BYTE;
		end else if (wr_event_mask) begin
			event_mask <= reg_wdata;
		end
	end

	// ************************************************************
	// scan dwell divider
	// ************************************************************
	localparam logic [rsf_pkg::DWELL_CNT_W-1:0] DWELL_LAST =
		rsf_pkg::DWELL_CNT_W'(rsf_pkg::SCAN_DWELL_CYCLES - 1);
	localparam logic [rsf_pkg::DWELL_CNT_W-1:0] DWELL_ZERO = '0;
	localparam logic [rsf_pkg::DWELL_CNT_W-1:0] DWELL_ONE = rsf_pkg::DWELL_CNT_W'(1);

	logic [rsf_pkg::DWELL_CNT_W-1:0] dwell_cnt;
	wire logic dwell_tick = (dwell_cnt == DWELL_LAST);
	wire logic [rsf_pkg::DWELL_CNT_W-1:0] next_dwell_cnt = dwell_tick ? DWELL_ZERO : (dwell_cnt + DWELL_ONE);

	rsf_pkg::rsf_scan_state_t scan_state;
	rsf_pkg::rsf_scan_state_t next_scan_state;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dwell_cnt <= DWELL_ZERO;
		end else if (scan_state != rsf_pkg::RSF_SCAN_RUN) begin
			dwell_cnt <= DWELL_ZERO;
		end else begin
			dwell_cnt <= next_dwell_cnt;
		end
	end

	// ************************************************************
	// channel scan sequencer
	// ************************************************************
	wire logic scan_start = wr_control && reg_wdata[rsf_pkg::CTRL_SCAN_START];
	wire logic at_range_end = (scan_channel == scan_last);
	wire logic judge = (scan_state == rsf_pkg::RSF_SCAN_RUN) && dwell_tick;
	wire logic scan_found = judge && channel_valid;
	wire logic scan_missed = judge && !channel_valid && at_range_end;
	wire logic scan_done = scan_found || scan_missed;

	always_comb begin
		next_scan_state = scan_state;
		case (scan_state)
			rsf_pkg::RSF_SCAN_IDLE: begin
				if (scan_start) begin
					next_scan_state = rsf_pkg::RSF_SCAN_LOAD;
				end
			end
			rsf_pkg::RSF_SCAN_LOAD: begin
				next_scan_state = rsf_pkg::RSF_SCAN_RUN;
			end
			rsf_pkg::RSF_SCAN_RUN: begin
				if (scan_done) begin
					next_scan_state = rsf_pkg::RSF_SCAN_IDLE;
				end
			end
			default: begin
				next_scan_state = rsf_pkg::RSF_SCAN_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scan_state <= rsf_pkg::RSF_SCAN_IDLE;
		end else begin
			scan_state <= next_scan_state;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scan_active <= rsf_pkg::RST_BIT;
		end else begin
			scan_active <= (next_scan_state != rsf_pkg::RSF_SCAN_IDLE);
		end
	end

	// index holds on a hit or at the range end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scan_channel <= rsf_pkg::RST_BYTE;
		end else if (scan_state == rsf_pkg::RSF_SCAN_LOAD) begin
			scan_channel <= scan_first;
		end else if (judge && !scan_done) begin
			scan_channel <= scan_channel + rsf_pkg::CHANNEL_STEP;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scan_fail <= rsf_pkg::RST_BIT;
		end else if (scan_found) begin
			scan_fail <= 1'b0;
		end else if (scan_missed) begin
			scan_fail <= 1'b1;
		end
	end

	// ************************************************************
	// group update toggle and transmit pulse
	// ************************************************************
	wire logic rx_group_event = !tx_mode && group_received;
	wire logic tx_group_event = tx_mode && group_fetched;
	wire logic group_event = rx_group_event || tx_group_event;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			group_toggle <= rsf_pkg::RST_BIT;
		end else if (group_event) begin
			group_toggle <= !group_toggle;
		end
	end

	localparam logic [rsf_pkg::PULSE_CNT_W-1:0] PULSE_ZERO = '0;
	localparam logic [rsf_pkg::PULSE_CNT_W-1:0] PULSE_ONE = rsf_pkg::PULSE_CNT_W'(1);
	localparam logic [rsf_pkg::PULSE_CNT_W-1:0] PULSE_LEN = rsf_pkg::PULSE_CNT_W'(GROUP_PULSE_CYCLES);

	logic [rsf_pkg::PULSE_CNT_W-1:0] pulse_cnt;
	wire logic pulse_start = tx_group_event && group_int_en;
	wire logic pulse_running = (pulse_cnt != PULSE_ZERO);
	wire logic [rsf_pkg::PULSE_CNT_W-1:0] next_pulse_cnt =
		pulse_start ? PULSE_LEN : (pulse_running ? (pulse_cnt - PULSE_ONE) : PULSE_ZERO);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pulse_cnt <= PULSE_ZERO;
		end else begin
			pulse_cnt <= next_pulse_cnt;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			group_int_n <= rsf_pkg::RST_PULSE_N;
		end else begin
			group_int_n <= (next_pulse_cnt == PULSE_ZERO);
		end
	end

	// ************************************************************
	// status register images
	// ************************************************************
	// live conditions except the registered scan_fail and group_toggle bits, nothing stored by writes
	wire logic [7:0] receive_status_image = {
		1'b0,
		scan_fail,
		audio_serial_overflow,
		audio_serial_underflow,
		input_saturated,
		gain_settled,
		gain_error,
		mono_indicator
	};

	wire logic [7:0] data_status_image = {
		group_toggle,
		extra_block_detect,
		third_block_type,
		block_sync,
		byte0_error_flag,
		byte1_error_flag,
		byte2_error_flag,
		byte3_error_flag
	};

	// ************************************************************
	// interrupt events
	// ************************************************************
	logic [rsf_pkg::EV_COUNT-1:0] event_status;
	logic [rsf_pkg::EV_COUNT-1:0] level_prev;
	wire logic [rsf_pkg::EV_COUNT-1:0] level_now;
	wire logic [rsf_pkg::EV_COUNT-1:0] event_hit;

	assign level_now[rsf_pkg::EV_SCAN_DONE] = 1'b0;
	assign level_now[rsf_pkg::EV_SCAN_FAIL] = 1'b0;
	assign level_now[rsf_pkg::EV_OVERFLOW] = audio_serial_overflow;
	assign level_now[rsf_pkg::EV_UNDERFLOW] = audio_serial_underflow;
	assign level_now[rsf_pkg::EV_SATURATION] = input_saturated;
	assign level_now[rsf_pkg::EV_GAIN_ERROR] = gain_error;
	assign level_now[rsf_pkg::EV_GROUP_TOGGLE] = 1'b0;
	assign level_now[rsf_pkg::EV_SYNC_LOST] = !block_sync;

	assign event_hit[rsf_pkg::EV_SCAN_DONE] = scan_done;
	assign event_hit[rsf_pkg::EV_SCAN_FAIL] = scan_missed;
	assign event_hit[rsf_pkg::EV_OVERFLOW] = level_now[rsf_pkg::EV_OVERFLOW] && !level_prev[rsf_pkg::EV_OVERFLOW];
	assign event_hit[rsf_pkg::EV_UNDERFLOW] = level_now[rsf_pkg::EV_UNDERFLOW] && !level_prev[rsf_pkg::EV_UNDERFLOW];
	assign event_hit[rsf_pkg::EV_SATURATION] =
		level_now[rsf_pkg::EV_SATURATION] && !level_prev[rsf_pkg::EV_SATURATION];
	assign event_hit[rsf_pkg::EV_GAIN_ERROR] =
		level_now[rsf_pkg::EV_GAIN_ERROR] && !level_prev[rsf_pkg::EV_GAIN_ERROR];
	assign event_hit[rsf_pkg::EV_GROUP_TOGGLE] = group_event;
	assign event_hit[rsf_pkg::EV_SYNC_LOST] = level_now[rsf_pkg::EV_SYNC_LOST] && !level_prev[rsf_pkg::EV_SYNC_LOST];

	// sync counts as lost out of reset, so no false sync-lost edge
	localparam logic [rsf_pkg::EV_COUNT-1:0] LEVEL_IDLE = rsf_pkg::EV_COUNT'(1) << rsf_pkg::EV_SYNC_LOST;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			level_prev <= LEVEL_IDLE;
		end else begin
			level_prev <= level_now;
		end
	end

	// sticky bits, set beats a write-one clear
	genvar gi;
	generate
		for (gi = 0; gi < rsf_pkg::EV_COUNT; gi = gi + 1) begin : g_event
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					event_status[gi] <= rsf_pkg::RST_BIT;
				end else if (event_hit[gi]) begin
					event_status[gi] <= 1'b1;
				end else if (wr_event_status && reg_wdata[gi]) begin
					event_status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	wire logic [rsf_pkg::EV_COUNT-1:0] next_event_status =
		event_hit | (event_status & ~(wr_event_status ? reg_wdata : rsf_pkg::RST_BYTE));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq <= rsf_pkg::RST_BIT;
		end else begin
			irq <= |(next_event_status & event_mask);
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	wire logic [7:0] read_mux =
		sel_receive_status ? receive_status_image :
		sel_data_status ? data_status_image :
		sel_control ? {5'h00, tx_mode, group_int_en, 1'b0} :
		sel_scan_first ? scan_first :
		sel_scan_last ? scan_last :
		sel_scan_channel ? scan_channel :
		sel_event_status ? event_status :
		sel_event_mask ? event_mask :
		rsf_pkg::RST_BYTE;

	// data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= rsf_pkg::RST_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= read_mux;
		end else begin
			reg_rdata <= rsf_pkg::RST_BYTE;
		end
	end

endmodule // rsf_status
